/* File: design/mcal_pkg.sv */
package mcal_pkg;

   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [9:0] IDX_ACTIVE_POWER_GAIN_A = 10'h0f6;
   localparam logic [9:0] IDX_PHASE_COMPENSATION = 10'h0f7;
   localparam logic [9:0] IDX_ACTIVE_POWER_LOWCUR_A = 10'h0f8;
   localparam logic [9:0] IDX_REACTIVE_POWER_GAIN_A = 10'h0f9;
   localparam logic [9:0] IDX_REACTIVE_POWER_GAIN_B = 10'h0fa;
   localparam logic [9:0] IDX_REACTIVE_POWER_LOWCUR_A = 10'h0fb;
   localparam logic [9:0] IDX_REACTIVE_POWER_LOWCUR_B = 10'h0fc;
   localparam logic [9:0] IDX_CURRENT_RMS_GAIN_A = 10'h0fd;
   localparam logic [9:0] IDX_CURRENT_RMS_LOWCUR_A = 10'h0fe;
   localparam logic [9:0] IDX_VOLTAGE_RMS_GAIN = 10'h0ff;
   localparam logic [9:0] IDX_ACTIVE_POWER_GAIN_B = 10'h100;
   localparam logic [9:0] IDX_ACTIVE_POWER_LOWCUR_B = 10'h101;
   localparam logic [9:0] IDX_CURRENT_RMS_GAIN_B = 10'h102;
   localparam logic [9:0] IDX_CURRENT_RMS_LOWCUR_B = 10'h103;
   localparam logic [9:0] IDX_ADC_BIAS_OFFSET_A = 10'h104;
   localparam logic [9:0] IDX_ADC_BIAS_OFFSET_B = 10'h105;
   localparam logic [9:0] IDX_VOLTAGE_ADC_BIAS_OFFSET = 10'h106;
   localparam logic [9:0] IDX_BANDPASS_COEFFICIENT = 10'h107;
   localparam logic [9:0] IDX_VOLTAGE_RMS_LOWCUR = 10'h108;
   localparam logic [9:0] IDX_CONFIG_CHECKSUM = 10'h109;
   localparam logic [9:0] IDX_SOFT_RESET_KEY = 10'h1be;

   // ---------------------------------------------------------------
   // bank shape, fields, values
   // ---------------------------------------------------------------
   localparam int unsigned MCAL_NREG = 19;
   localparam logic [4:0] SLOT_PHASE = 5'h01;
   localparam logic [4:0] SLOT_BPF = 5'h11;
   localparam int unsigned PH_B_MSB = 24;
   localparam int unsigned PH_B_LSB = 16;
   localparam int unsigned PH_A_MSB = 8;
   localparam int unsigned PH_A_LSB = 0;
   localparam logic [31:0] CAL_RESET = 32'h0000_0000;
   localparam logic [31:0] SOFT_RESET_KEY = 32'h4572_beaf;
   localparam logic [31:0] CHECK_TARGET = 32'hffff_ffff;
   // value the host loads when sampling runs near 3.2 MHz
   localparam logic [31:0] BPF_COEF_3M2 = 32'h8067_64b6;

   typedef logic [MCAL_NREG-1:0][31:0] mcal_bank_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } mcal_apb_req_s;

   // one step is 0.005 degree at 3.2768 MHz sampling, range +/-1.28 degree
   typedef struct packed {
      logic signed [8:0] chan_b;
      logic signed [8:0] chan_a;
   } mcal_phase_s;

endpackage

/* File: design/mcal_regs.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module mcal_regs
   import mcal_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // receive-line reset and external configuration sum
   input wire logic i_rx_rst,
   input wire logic [31:0] i_cfg_sum,
   // apb slave
   input wire mcal_apb_req_s i_apb,
   output var logic o_pready,
   output var logic [31:0] o_prdata,
   output var logic o_pslverr,
   // values to the metering datapath
   output var mcal_bank_t o_cal,
   output var mcal_phase_s o_phase,
   output var logic o_ph_a_dly_volt,
   output var logic o_ph_b_dly_volt,
   output var logic [31:0] o_bpf_coef,
   // system status
   output var logic o_cfg_ok,
   output var logic o_sys_rst
);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // the bank is one contiguous run of indices, one slot per register
   function automatic logic in_bank(input logic [9:0] idx);
      in_bank = (idx >= IDX_ACTIVE_POWER_GAIN_A) && (idx <= IDX_VOLTAGE_RMS_LOWCUR);
   endfunction

   function automatic logic [4:0] slot_of(input logic [9:0] idx);
      logic [9:0] diff;
      diff = idx - IDX_ACTIVE_POWER_GAIN_A;
      slot_of = diff[4:0];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      merge = res;
   endfunction

   function automatic logic [31:0] bank_sum(input mcal_bank_t bank);
      logic [31:0] acc;
      acc = 32'h0000_0000;
      for (int i = 0; i < MCAL_NREG; i++) begin
         acc = acc + bank[i];
      end
      bank_sum = acc;
   endfunction

   // ---------------------------------------------------------------
   // bus phase decode
   // ---------------------------------------------------------------
   logic [9:0] word_idx;
   logic setup_ph;
   logic wr_take;
   logic hit_bank;
   logic hit_checksum;
   logic hit_key;
   logic mapped;
   logic [4:0] slot;
   logic clr_all;
   logic [31:0] checksum_q;

   assign word_idx = i_apb.paddr[11:2];
   assign setup_ph = i_apb.psel && !i_apb.penable;
   // a write lands only at the edge where the master sees pready
   assign wr_take = i_apb.psel && i_apb.penable && o_pready && i_apb.pwrite;
   assign hit_bank = in_bank(word_idx);
   assign hit_checksum = (word_idx == IDX_CONFIG_CHECKSUM);
   assign hit_key = (word_idx == IDX_SOFT_RESET_KEY);
   assign mapped = hit_bank || hit_checksum || hit_key;
   assign slot = slot_of(word_idx);
   // all three reset sources act alike on the bank
   assign clr_all = !i_rst_n || i_rx_rst || o_sys_rst;

   // ---------------------------------------------------------------
   // apb answer: one wait-free access phase after setup
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= setup_ph;
         o_pslverr <= setup_ph && !mapped;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_prdata <= 32'h0000_0000;
      end else if (setup_ph && !i_apb.pwrite) begin
         if (hit_bank) begin
            o_prdata <= o_cal[slot];
         end else if (hit_checksum) begin
            o_prdata <= checksum_q;
         end else begin
            // the key register and unmapped words read as zero
            o_prdata <= 32'h0000_0000;
         end
      end
   end

   // ---------------------------------------------------------------
   // calibration bank
   // ---------------------------------------------------------------
   // the bank drives the datapath directly, so a write counts from the
   // next cycle; a half-written multi-lane update is the host's concern
   always_ff @(posedge i_mclk) begin
      if (clr_all) begin
         o_cal <= '0;
      end else if (wr_take && hit_bank) begin
         o_cal[slot] <= merge(o_cal[slot], i_apb.pwdata, i_apb.pstrb);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (clr_all) begin
         checksum_q <= CAL_RESET;
      end else if (wr_take && hit_checksum) begin
         checksum_q <= merge(checksum_q, i_apb.pwdata, i_apb.pstrb);
      end
   end

   // ---------------------------------------------------------------
   // software reset key
   // ---------------------------------------------------------------
   // full word must match; partial strobes never arm the reset
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_sys_rst <= 1'b0;
      end else begin
         o_sys_rst <= wr_take && hit_key && (i_apb.pstrb == 4'hf)
                      && (i_apb.pwdata == SOFT_RESET_KEY);
      end
   end

   // ---------------------------------------------------------------
   // configuration check
   // ---------------------------------------------------------------
   logic [31:0] total;
   assign total = bank_sum(o_cal) + checksum_q + i_cfg_sum;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_cfg_ok <= 1'b0;
      end else begin
         o_cfg_ok <= (total == CHECK_TARGET);
      end
   end

   // ---------------------------------------------------------------
   // field views for the datapath
   // ---------------------------------------------------------------
   // sign bit set means delay the voltage path, clear means current path
   assign o_phase.chan_b = o_cal[SLOT_PHASE][PH_B_MSB:PH_B_LSB];
   assign o_phase.chan_a = o_cal[SLOT_PHASE][PH_A_MSB:PH_A_LSB];
   assign o_ph_b_dly_volt = o_cal[SLOT_PHASE][PH_B_MSB];
   assign o_ph_a_dly_volt = o_cal[SLOT_PHASE][PH_A_MSB];
   // the coefficient is not range-checked, only summed into the configuration check;
   // a wrong value also degrades frequency and phase measurement
   assign o_bpf_coef = o_cal[SLOT_BPF];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_mclk);
   endclocking

   default disable iff (!i_rst_n);

   rx_clear_a: assert property (
      i_rx_rst |=> (o_cal == '0) && (checksum_q == 32'h0000_0000))
      else $error("receive-line reset left the bank dirty");

   key_reset_a: assert property (
      (wr_take && hit_key && i_apb.pstrb == 4'hf && i_apb.pwdata == SOFT_RESET_KEY)
      |=> o_sys_rst ##1 (o_cal == '0) && !o_sys_rst)
      else $error("key write did not reset the bank");

   wr_apply_a: assert property (
      (wr_take && hit_bank && i_apb.pstrb == 4'hf && !i_rx_rst && !o_sys_rst)
      |=> o_cal[$past(slot)] == $past(i_apb.pwdata))
      else $error("bank write not applied next cycle");

   rd_back_a: assert property (
      (setup_ph && !i_apb.pwrite && hit_bank)
      |=> o_pready && !o_pslverr && (o_prdata == $past(o_cal[slot])))
      else $error("bank read returned wrong data");

   unmap_err_a: assert property (
      (setup_ph && !mapped) |=> o_pready && o_pslverr ##1 !o_pready)
      else $error("unmapped access not flagged");

   sum_check_a: assert property (
      ##1 o_cfg_ok == ($past(bank_sum(o_cal) + checksum_q + i_cfg_sum) == CHECK_TARGET))
      else $error("configuration check mismatch");

   phase_b_a: assert property (
      $changed(o_cal[SLOT_PHASE][24:16]) |-> o_phase.chan_b != $past(o_phase.chan_b)
      && o_ph_b_dly_volt == o_phase.chan_b[8])
      else $error("channel b phase field wrong");

   phase_a_a: assert property (
      $changed(o_cal[SLOT_PHASE][8:0]) |-> o_phase.chan_a != $past(o_phase.chan_a)
      && o_ph_a_dly_volt == o_phase.chan_a[8])
      else $error("channel a phase field wrong");

   bpf_out_a: assert property (
      (wr_take && slot == SLOT_BPF && hit_bank && i_apb.pstrb == 4'hf
       && !i_rx_rst && !o_sys_rst)
      |=> o_bpf_coef == $past(i_apb.pwdata))
      else $error("band-pass coefficient not passed on");

   // ---------------------------------------------------------------
   // bus handshake checks
   // ---------------------------------------------------------------
   // the slave never stretches the access phase, so ready is a pure echo of setup

   ready_after_setup_a: assert property (
      setup_ph
      |=> o_pready)
      else $error("pready missing after setup");

   ready_source_a: assert property (
      o_pready
      |-> $past(setup_ph))
      else $error("pready without a setup cycle");

   ready_idle_a: assert property (
      !i_apb.psel
      |=> !o_pready)
      else $error("pready raised on an idle bus");

   err_with_ready_a: assert property (
      o_pslverr
      |-> o_pready)
      else $error("pslverr outside the access phase");

   mapped_no_err_a: assert property (
      (setup_ph && mapped)
      |=> !o_pslverr)
      else $error("mapped access flagged as error");

   unmap_rd_zero_a: assert property (
      (setup_ph && !i_apb.pwrite && !mapped)
      |=> o_prdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   key_rd_zero_a: assert property (
      (setup_ph && !i_apb.pwrite && hit_key)
      |=> o_prdata == 32'h0000_0000)
      else $error("key register read returned data");

   sum_rd_back_a: assert property (
      (setup_ph && !i_apb.pwrite && hit_checksum)
      |=> o_prdata == $past(checksum_q))
      else $error("checksum read returned wrong data");

   rd_hold_a: assert property (
      !(setup_ph && !i_apb.pwrite)
      |=> $stable(o_prdata))
      else $error("read data moved without a read");

   // ---------------------------------------------------------------
   // write effect checks
   // ---------------------------------------------------------------
   // a refused or read access must leave every stored word alone

   unmap_no_write_a: assert property (
      (wr_take && !mapped && !i_rx_rst && !o_sys_rst)
      |=> $stable(o_cal) && $stable(checksum_q))
      else $error("unmapped write changed the bank");

   read_no_write_a: assert property (
      (i_apb.psel && i_apb.penable && o_pready && !i_apb.pwrite && !i_rx_rst && !o_sys_rst)
      |=> $stable(o_cal) && $stable(checksum_q))
      else $error("read changed the bank");

   sum_apply_a: assert property (
      (wr_take && hit_checksum && i_apb.pstrb == 4'hf && !i_rx_rst && !o_sys_rst)
      |=> checksum_q == $past(i_apb.pwdata))
      else $error("checksum write not applied");

   bpf_hold_a: assert property (
      (!(wr_take && hit_bank && slot == SLOT_BPF) && !i_rx_rst && !o_sys_rst)
      |=> $stable(o_bpf_coef))
      else $error("band-pass coefficient moved without a write");

   phase_hold_a: assert property (
      (!(wr_take && hit_bank && slot == SLOT_PHASE) && !i_rx_rst && !o_sys_rst)
      |=> $stable(o_phase))
      else $error("phase fields moved without a write");

   // ---------------------------------------------------------------
   // reset checks
   // ---------------------------------------------------------------
   // the power-on check must run while reset is low, so it drops the default disable

   por_clear_a: assert property (disable iff (1'b0)
      !i_rst_n
      |=> (o_cal == '0) && !o_pready && !o_sys_rst && !o_cfg_ok)
      else $error("power-on reset left state behind");

   sys_clear_a: assert property (
      o_sys_rst
      |=> (o_cal == '0) && (checksum_q == 32'h0000_0000))
      else $error("software reset left the bank dirty");

   key_partial_a: assert property (
      (wr_take && hit_key && i_apb.pstrb != 4'hf)
      |=> !o_sys_rst)
      else $error("partial key write armed the reset");

   key_wrong_a: assert property (
      (wr_take && hit_key && i_apb.pwdata != SOFT_RESET_KEY)
      |=> !o_sys_rst)
      else $error("wrong key value armed the reset");

   rst_pulse_one_a: assert property (
      o_sys_rst
      |=> !o_sys_rst)
      else $error("software reset pulse too long");

   cfg_low_a: assert property (
      (total != CHECK_TARGET)
      |=> !o_cfg_ok)
      else $error("configuration check passed on a bad sum");

endmodule
`default_nettype wire

/* File: bench/mcal_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module mcal_regs_bench
   import mcal_pkg::*;
;
   // ------------------------------------------------------------
   // design and stimulus signals
   // ------------------------------------------------------------
   logic i_mclk;
   logic i_rst_n;
   logic i_rx_rst;
   logic [31:0] i_cfg_sum;
   mcal_apb_req_s i_apb;
   logic o_pready;
   logic [31:0] o_prdata;
   logic o_pslverr;
   mcal_bank_t o_cal;
   mcal_phase_s o_phase;
   logic o_ph_a_dly_volt;
   logic o_ph_b_dly_volt;
   logic [31:0] o_bpf_coef;
   logic o_cfg_ok;
   logic o_sys_rst;
   int n_fail;
   int cmp_count;
   int i;
   int k;
   int hi;
   logic [31:0] exp_bank [MCAL_NREG];
   logic [31:0] ph [2];
   logic [31:0] sum;

   mcal_regs dut (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_rx_rst(i_rx_rst), .i_cfg_sum(i_cfg_sum),
      .i_apb(i_apb), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
      .o_cal(o_cal), .o_phase(o_phase), .o_ph_a_dly_volt(o_ph_a_dly_volt),
      .o_ph_b_dly_volt(o_ph_b_dly_volt), .o_bpf_coef(o_bpf_coef), .o_cfg_ok(o_cfg_ok),
      .o_sys_rst(o_sys_rst)
   );

   always #50 i_mclk = ~i_mclk;

   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask

   // one apb transfer; a read compares data, both compare the error flag
   task automatic acc(input logic w, input logic [9:0] idx, input logic [31:0] d,
                      input logic e);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_apb.psel <= 1'b1;
      i_apb.penable <= 1'b0;
      i_apb.pwrite <= w;
      i_apb.paddr <= {idx, 2'b00};
      i_apb.pwdata <= w ? d : 32'h0000_0000;
      i_apb.pstrb <= 4'hf;
      @(posedge i_mclk);
      i_apb.penable <= 1'b1;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      if (o_pready !== 1'b1) begin
         $display("wrong value pready expected 1 seen %b", o_pready);
         n_fail++;
         complete_run();
      end
      if (!w) begin
         chk("prdata", d, o_prdata);
      end
      chk("pslverr", {31'h0, e}, {31'h0, o_pslverr});
      i_apb.psel <= 1'b0;
      i_apb.penable <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      i_mclk = 1'b0;
      i_rst_n = 1'b0;
      i_rx_rst = 1'b0;
      i_cfg_sum = 32'h1234_5678;
      i_apb = '0;
      n_fail = 0;
      cmp_count = 0;
      ph[0] = 32'hfdff_5100;
      ph[1] = 32'h00ff_00ff;
      repeat (12) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      for (i = 0; i < MCAL_NREG; i++) begin
         exp_bank[i] = 32'h8000_0001 + 32'(i) * 32'h0011_2233;
         acc(1'b0, IDX_ACTIVE_POWER_GAIN_A + 10'(i), CAL_RESET, 1'b0);
         acc(1'b1, IDX_ACTIVE_POWER_GAIN_A + 10'(i), exp_bank[i], 1'b0);
      end
      @(negedge i_mclk);
      for (i = 0; i < MCAL_NREG; i++) begin
         chk("o_cal", exp_bank[i], o_cal[i]);
         acc(1'b0, IDX_ACTIVE_POWER_GAIN_A + 10'(i), exp_bank[i], 1'b0);
      end
      // both sign settings of each phase field
      for (k = 0; k < 2; k++) begin
         acc(1'b1, IDX_PHASE_COMPENSATION, ph[k], 1'b0);
         @(negedge i_mclk);
         chk("chan_b", {23'h0, ph[k][24:16]}, {23'h0, o_phase.chan_b});
         chk("dly_b", {31'h0, ph[k][24]}, {31'h0, o_ph_b_dly_volt});
         chk("chan_a", {23'h0, ph[k][8:0]}, {23'h0, o_phase.chan_a});
         chk("dly_a", {31'h0, ph[k][8]}, {31'h0, o_ph_a_dly_volt});
      end
      exp_bank[SLOT_PHASE] = ph[1];
      acc(1'b1, IDX_BANDPASS_COEFFICIENT, BPF_COEF_3M2, 1'b0);
      @(negedge i_mclk);
      chk("bpf", BPF_COEF_3M2, o_bpf_coef);
      exp_bank[SLOT_BPF] = BPF_COEF_3M2;
      sum = i_cfg_sum;
      for (i = 0; i < MCAL_NREG; i++) begin
         sum = sum + exp_bank[i];
      end
      acc(1'b1, IDX_CONFIG_CHECKSUM, CHECK_TARGET - sum, 1'b0);
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      chk("cfg_ok", 32'h1, {31'h0, o_cfg_ok});
      acc(1'b1, IDX_VOLTAGE_RMS_LOWCUR, exp_bank[18] + 32'h1, 1'b0);
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      chk("cfg_ok", 32'h0, {31'h0, o_cfg_ok});
      // an unmapped word below the bank, and the write-only key
      acc(1'b0, 10'h0f5, 32'h0, 1'b1);
      acc(1'b1, 10'h0f5, 32'hffff_ffff, 1'b1);
      acc(1'b0, IDX_SOFT_RESET_KEY, 32'h0, 1'b0);
      acc(1'b1, IDX_SOFT_RESET_KEY, SOFT_RESET_KEY ^ 32'h1, 1'b0);
      acc(1'b0, IDX_ACTIVE_POWER_GAIN_A, exp_bank[0], 1'b0);
      acc(1'b1, IDX_SOFT_RESET_KEY, SOFT_RESET_KEY, 1'b0);
      hi = 0;
      repeat (4) begin
         @(negedge i_mclk);
         if (o_sys_rst === 1'b1) hi++;
      end
      chk("sys_rst cycles", 32'h1, 32'(hi));
      for (i = 0; i < MCAL_NREG; i++) begin
         acc(1'b0, IDX_ACTIVE_POWER_GAIN_A + 10'(i), CAL_RESET, 1'b0);
      end
      acc(1'b0, IDX_CONFIG_CHECKSUM, 32'h0, 1'b0);
      acc(1'b1, IDX_VOLTAGE_RMS_GAIN, 32'h5a5a_a5a5, 1'b0);
      @(posedge i_mclk);
      i_rx_rst <= 1'b1;
      @(posedge i_mclk);
      i_rx_rst <= 1'b0;
      acc(1'b0, IDX_VOLTAGE_RMS_GAIN, CAL_RESET, 1'b0);
      acc(1'b1, IDX_ADC_BIAS_OFFSET_A, 32'hc3c3_3c3c, 1'b0);
      @(posedge i_mclk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      acc(1'b0, IDX_ADC_BIAS_OFFSET_A, CAL_RESET, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
